// ==== rtl/asp_pkg.sv ====
package asp_pkg;
  // register byte offsets
  localparam logic [7:0] ASP_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ASP_OFS_SLOT   = 8'h04;
  localparam logic [7:0] ASP_OFS_WARN   = 8'h08;
  localparam logic [7:0] ASP_OFS_STAT   = 8'h0C;
  localparam logic [7:0] ASP_OFS_RXFIFO = 8'h10;
  localparam logic [7:0] ASP_OFS_TXFIFO = 8'h14;
  localparam logic [7:0] ASP_OFS_RXHOLD = 8'h20;
  localparam logic [7:0] ASP_OFS_TXHOLD = 8'h30;
  localparam logic [7:0] ASP_HOLD_MASK  = 8'hF3;
  // control register fields
  localparam int ASP_CTRL_EN     = 0;
  localparam int ASP_CTRL_MASTER = 1;
  localparam int ASP_CTRL_CLKSEL = 2;
  localparam int ASP_CTRL_WORD16 = 3;
  localparam int ASP_CTRL_SCS    = 4;
  localparam int ASP_CTRL_BCPRS  = 8;
  localparam int ASP_CTRL_FRAME_CLOCK_DIVIDER  = 16;
  // slot register fields
  localparam int ASP_SLOT_TX_SLOT_ASSIGN = 0;
  localparam int ASP_SLOT_RX_SLOT_ASSIGN = 4;
  localparam int ASP_SLOT_TXDS = 8;
  localparam int ASP_SLOT_RXDS = 12;
  // warning and status fields
  localparam int ASP_WARN_RX    = 0;
  localparam int ASP_WARN_TX    = 8;
  localparam int ASP_STAT_RXCNT = 0;
  localparam int ASP_STAT_TXCNT = 8;
  localparam int ASP_STAT_RXFUL = 16;
  localparam int ASP_STAT_TXFUL = 20;
  // widths and limits
  localparam int ASP_SLOTS     = 4;
  localparam int ASP_BCPRS_W   = 8;
  localparam int ASP_FRAME_CLOCK_DIVIDER_W   = 7;
  localparam int ASP_WORD_W    = 16;
  localparam int ASP_CNT_W     = 5;
  localparam logic [3:0] ASP_LAST_BIT_8  = 4'h7;
  localparam logic [3:0] ASP_LAST_BIT_16 = 4'hF;
  localparam logic [4:0] ASP_RST_WARN    = 5'h08;
  // selectable prescaler input clocks
  localparam int ASP_PRI_CLK_MHZ = 12;
  localparam int ASP_SEC_CLK_MHZ = 48;
endpackage

// ==== rtl/asp_serial_port.sv ====
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - tx and rx share one shift clock and frame sync from one prescaler
// - normal mode: each frame sync rise starts a frame and its slot
// - only bits sampled after the frame sync are kept
// - normal mode: words go to rx fifo or rx holding zero
// - data pin driven only while word bits shift out
// - rx irq while rx fifo count exceeds warning limit; here only while an assigned rx slot uses the fifo
// - tx irq while tx fifo count at or below warning limit; here only while an assigned tx slot uses the fifo
// - rx dma request while rx holding zero is full
// - tx dma request while tx holding zero is empty
// - network mode: equal 8 or 16 bit slots after frame sync
// - at most four slots per frame, all assignable here
// - tx drives data only in assigned slots, else released
// - each tx slot sources fifo or its own holding register
// - rx stores only assigned slots, to fifo or own holding
// - rx dma slot writes only its holding register, requests when full
// - tx dma slot reads its holding register, requests when empty
// - sync network master: aux syncs at slot one and slot two
// - one master drives clock and sync; slaves take them as inputs
// - bit clock is selected input divided by prescaler plus one
// - prescaler input selectable: 12 MHz primary or 48 MHz secondary
// - tx changes on rising, rx samples on falling, msb first
// - frame length is bit clock divided by frame prescaler plus one
// - rx and tx fifos each hold 16 words
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        clk_primary_in,
  input  wire logic        clk_secondary_in,
  input  wire logic        shift_clock_pin_in,
  output logic             shift_clock_pin_out,
  output logic             shift_clock_pin_oe_out,
  input  wire logic        tx_frame_sync_pin_in,
  output logic             tx_frame_sync_pin_out,
  output logic             tx_frame_sync_pin_oe_out,
  output logic             ser_tx_data_pin_out,
  output logic             ser_tx_data_pin_oe_out,
  input  wire logic        ser_rx_data_pin_in,
  output logic             rx_bit_clock_pin_out,
  output logic             rx_bit_clock_pin_oe_out,
  output logic             rx_frame_sync_pin_out,
  output logic             rx_frame_sync_pin_oe_out,
  output logic             rx_irq_out,
  output logic             tx_irq_out,
  output logic [3:0]       rx_dma_req_out,
  output logic [3:0]       tx_dma_req_out
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [ASP_CNT_W-1:0] DEPTH = ASP_CNT_W'(FIFO_DEPTH);

  typedef struct packed {
    logic                               en;
    logic                               master;
    logic                               clk_sel;
    logic                               word16;
    logic [1:0]                         slot_count_select;
    logic [ASP_BCPRS_W-1:0]             bit_clock_divider;
    logic [ASP_FRAME_CLOCK_DIVIDER_W-1:0]             frame_clock_divider;
    logic [3:0]                         tx_slot_assign;
    logic [3:0]                         rx_slot_assign;
    logic [3:0]                         tx_slotn_dma_sel;
    logic [3:0]                         rx_slotn_dma_sel;
    logic [ASP_CNT_W-1:0]               rx_warn;
    logic [ASP_CNT_W-1:0]               tx_warn;
    logic                               clk_prev;
    logic                               sck_prev;
    logic                               fs_prev;
    logic                               fs_seen;
    logic [ASP_BCPRS_W-1:0]             div_cnt;
    logic [ASP_FRAME_CLOCK_DIVIDER_W-1:0]             pos;
    logic [3:0]                         bit_cnt;
    logic [2:0]                         slot_cnt;
    logic                               in_frame;
    logic [ASP_WORD_W-1:0]              tx_shift_reg;
    logic [ASP_WORD_W-1:0]              tx_last;
    logic [ASP_WORD_W-1:0]              rx_shift_reg;
    logic [FIFO_DEPTH-1:0][ASP_WORD_W-1:0] rxf;
    logic [FIFO_DEPTH-1:0][ASP_WORD_W-1:0] txf;
    logic [AW-1:0]                      rx_wp;
    logic [AW-1:0]                      rx_rp;
    logic [AW-1:0]                      tx_wp;
    logic [AW-1:0]                      tx_rp;
    logic [ASP_CNT_W-1:0]               rx_cnt;
    logic [ASP_CNT_W-1:0]               tx_cnt;
    logic [3:0][ASP_WORD_W-1:0]         rx_dma_holding_n;
    logic [3:0][ASP_WORD_W-1:0]         tx_dma_holding_n;
    logic [3:0]                         rx_full;
    logic [3:0]                         tx_full;
    logic                               sck;
    logic                               sck_oe;
    logic                               fs_out;
    logic                               fs_oe;
    logic                               tx_oe;
    logic                               aux1;
    logic                               aux2;
    logic                               aux_oe;
    logic                               rx_irq;
    logic                               tx_irq;
    logic [3:0]                         rx_dreq;
    logic [3:0]                         tx_dreq;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
  } asp_state_t;

  asp_state_t s;
  asp_state_t n;

  logic                  sel_clk;
  logic                  in_rise;
  logic                  rise_ev;
  logic                  fall_ev;
  logic                  start;
  logic [3:0]            last_bit;
  logic [ASP_BCPRS_W-1:0] half;
  logic [ASP_WORD_W-1:0] word;
  logic [ASP_WORD_W-1:0] rx_word;
  logic [1:0]            sl;
  logic                  rx_push;
  logic                  rx_pop;
  logic                  tx_push;
  logic                  tx_pop;
  logic                  acc;
  logic [7:0]            ofs;

  always_comb begin
    n        = s;
    sel_clk  = s.clk_sel ? clk_secondary_in : clk_primary_in;
    in_rise  = sel_clk && !s.clk_prev;
    half     = ASP_BCPRS_W'((9'(s.bit_clock_divider) + 9'h001) >> 1);
    last_bit = s.word16 ? ASP_LAST_BIT_16 : ASP_LAST_BIT_8;
    start    = 1'b0;
    word     = '0;
    rx_word  = '0;
    sl       = s.slot_cnt[1:0];
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    acc      = psel_in && penable_in && s.pready;
    ofs      = paddr_in[7:0];
    n.clk_prev = sel_clk;
    n.sck_prev = shift_clock_pin_in;
    // one edge pair for both paths
    if (s.master) begin
      rise_ev = in_rise && (s.div_cnt == '0);
      fall_ev = (s.bit_clock_divider == '0) ? (!sel_clk && s.clk_prev)
                                            : (in_rise && s.div_cnt == half);
    end else begin
      rise_ev = shift_clock_pin_in && !s.sck_prev;
      fall_ev = !shift_clock_pin_in && s.sck_prev;
    end
    if (in_rise) begin
      n.div_cnt = (s.div_cnt == s.bit_clock_divider) ? '0
                                                     : s.div_cnt + 1'b1;
    end
    if (!s.en) begin
      rise_ev = 1'b0;
      fall_ev = 1'b0;
      n.in_frame = 1'b0;
      n.tx_oe    = 1'b0;
      n.fs_out   = 1'b0;
      n.sck      = 1'b0;
      n.div_cnt  = '0;
      n.pos      = '0;
      n.fs_seen  = 1'b0;
    end
    if (rise_ev) begin
      n.sck     = 1'b1;
      n.fs_seen = 1'b0;
      if (s.master) begin
        n.pos = (s.pos == s.frame_clock_divider) ? '0 : s.pos + 1'b1;
        start = (n.pos == '0);
        n.fs_out = start;
      end else begin
        start = s.fs_seen;
      end
      // slot counter
      if (start) begin
        n.bit_cnt  = '0;
        n.slot_cnt = '0;
        n.in_frame = 1'b1;
      end else if (s.in_frame) begin
        if (s.bit_cnt == last_bit) begin
          n.bit_cnt = '0;
          if (s.slot_cnt[1:0] == s.slot_count_select) begin
            n.in_frame = 1'b0;
          end else begin
            n.slot_cnt = s.slot_cnt + 1'b1;
          end
        end else begin
          n.bit_cnt = s.bit_cnt + 1'b1;
        end
      end
      sl = n.slot_cnt[1:0];
      if (n.in_frame && s.tx_slot_assign[sl]) begin
        n.tx_oe = 1'b1;
        if (n.bit_cnt == '0) begin
          if (s.tx_slotn_dma_sel[sl]) begin
            word = s.tx_dma_holding_n[sl];
            n.tx_full[sl] = 1'b0;
          end else if (s.tx_cnt != '0) begin
            word = s.txf[s.tx_rp];
            tx_pop = 1'b1;
            n.tx_last = word; // fifo words only, dma slots keep their own
          end else begin
            word = s.tx_last; // underrun repeats the previous fifo word
          end
          n.tx_shift_reg = s.word16 ? word : {word[7:0], 8'h00};
        end else begin
          n.tx_shift_reg = {s.tx_shift_reg[ASP_WORD_W-2:0], 1'b0};
        end
      end else begin
        n.tx_oe = 1'b0;
      end
      // aux syncs mark slot one and two starts; their pins are enabled only for a network master
      n.aux1 = n.in_frame && n.slot_cnt == 3'h1 && n.bit_cnt == '0;
      n.aux2 = n.in_frame && n.slot_cnt == 3'h2 && n.bit_cnt == '0;
    end
    if (fall_ev) begin
      n.sck     = 1'b0;
      n.fs_prev = tx_frame_sync_pin_in;
      if (!s.master && tx_frame_sync_pin_in && !s.fs_prev) begin
        n.fs_seen = 1'b1;
      end
      if (s.in_frame && s.rx_slot_assign[sl]) begin
        n.rx_shift_reg = {s.rx_shift_reg[ASP_WORD_W-2:0],
                          ser_rx_data_pin_in};
        if (s.bit_cnt == last_bit) begin
          rx_word = s.word16 ? n.rx_shift_reg
                             : {8'h00, n.rx_shift_reg[7:0]};
          if (s.rx_slotn_dma_sel[sl]) begin
            n.rx_dma_holding_n[sl] = rx_word; // overwrite if still full
          end else if (s.rx_cnt != DEPTH) begin
            rx_push = 1'b1;
          end
        end
      end
    end
    // apb register access, read data taken in the setup phase, writes at the access edge
    if (psel_in && !penable_in) begin
      n.pready  = 1'b1;
      n.pslverr = 1'b0;
      n.prdata  = '0;
      case (ofs)
        ASP_OFS_CTRL: begin
          n.prdata[ASP_CTRL_EN]     = s.en;
          n.prdata[ASP_CTRL_MASTER] = s.master;
          n.prdata[ASP_CTRL_CLKSEL] = s.clk_sel;
          n.prdata[ASP_CTRL_WORD16] = s.word16;
          n.prdata[ASP_CTRL_SCS +: 2] = s.slot_count_select;
          n.prdata[ASP_CTRL_BCPRS +: ASP_BCPRS_W] = s.bit_clock_divider;
          n.prdata[ASP_CTRL_FRAME_CLOCK_DIVIDER +: ASP_FRAME_CLOCK_DIVIDER_W] = s.frame_clock_divider;
        end
        ASP_OFS_SLOT: begin
          n.prdata[ASP_SLOT_TX_SLOT_ASSIGN +: 4] = s.tx_slot_assign;
          n.prdata[ASP_SLOT_RX_SLOT_ASSIGN +: 4] = s.rx_slot_assign;
          n.prdata[ASP_SLOT_TXDS +: 4] = s.tx_slotn_dma_sel;
          n.prdata[ASP_SLOT_RXDS +: 4] = s.rx_slotn_dma_sel;
        end
        ASP_OFS_WARN: begin
          n.prdata[ASP_WARN_RX +: ASP_CNT_W] = s.rx_warn;
          n.prdata[ASP_WARN_TX +: ASP_CNT_W] = s.tx_warn;
        end
        ASP_OFS_STAT: begin
          n.prdata[ASP_STAT_RXCNT +: ASP_CNT_W] = s.rx_cnt;
          n.prdata[ASP_STAT_TXCNT +: ASP_CNT_W] = s.tx_cnt;
          n.prdata[ASP_STAT_RXFUL +: 4] = s.rx_full;
          n.prdata[ASP_STAT_TXFUL +: 4] = s.tx_full;
        end
        ASP_OFS_RXFIFO: n.prdata[ASP_WORD_W-1:0] = s.rxf[s.rx_rp];
        ASP_OFS_TXFIFO: n.prdata = '0;
        default: begin
          if ((ofs & ASP_HOLD_MASK) == ASP_OFS_RXHOLD) begin
            n.prdata[ASP_WORD_W-1:0] = s.rx_dma_holding_n[ofs[3:2]];
          end else if ((ofs & ASP_HOLD_MASK) == ASP_OFS_TXHOLD) begin
            n.prdata[ASP_WORD_W-1:0] = s.tx_dma_holding_n[ofs[3:2]];
          end else begin
            n.pslverr = 1'b1;
          end
        end
      endcase
    end else begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
    end
    if (acc && pwrite_in) begin
      case (ofs)
        ASP_OFS_CTRL: begin
          n.en      = pwdata_in[ASP_CTRL_EN];
          n.master  = pwdata_in[ASP_CTRL_MASTER];
          n.clk_sel = pwdata_in[ASP_CTRL_CLKSEL];
          n.word16  = pwdata_in[ASP_CTRL_WORD16];
          n.slot_count_select   = pwdata_in[ASP_CTRL_SCS +: 2];
          n.bit_clock_divider   = pwdata_in[ASP_CTRL_BCPRS +: ASP_BCPRS_W];
          n.frame_clock_divider = pwdata_in[ASP_CTRL_FRAME_CLOCK_DIVIDER +: ASP_FRAME_CLOCK_DIVIDER_W];
        end
        ASP_OFS_SLOT: begin
          n.tx_slot_assign   = pwdata_in[ASP_SLOT_TX_SLOT_ASSIGN +: 4];
          n.rx_slot_assign   = pwdata_in[ASP_SLOT_RX_SLOT_ASSIGN +: 4];
          n.tx_slotn_dma_sel = pwdata_in[ASP_SLOT_TXDS +: 4];
          n.rx_slotn_dma_sel = pwdata_in[ASP_SLOT_RXDS +: 4];
        end
        ASP_OFS_WARN: begin
          n.rx_warn = pwdata_in[ASP_WARN_RX +: ASP_CNT_W];
          n.tx_warn = pwdata_in[ASP_WARN_TX +: ASP_CNT_W];
        end
        ASP_OFS_TXFIFO: tx_push = (s.tx_cnt != DEPTH);
        default: begin
          if ((ofs & ASP_HOLD_MASK) == ASP_OFS_TXHOLD) begin
            n.tx_dma_holding_n[ofs[3:2]] = pwdata_in[ASP_WORD_W-1:0];
            n.tx_full[ofs[3:2]] = 1'b1; // new word wins over a take
          end
        end
      endcase
    end
    if (acc && !pwrite_in) begin
      if (ofs == ASP_OFS_RXFIFO) begin
        rx_pop = (s.rx_cnt != '0);
      end else if ((ofs & ASP_HOLD_MASK) == ASP_OFS_RXHOLD) begin
        n.rx_full[ofs[3:2]] = 1'b0;
      end
    end
    // a word landing in the same cycle as the read keeps the flag set
    if (fall_ev && s.in_frame && s.rx_slot_assign[sl] &&
        s.bit_cnt == last_bit && s.rx_slotn_dma_sel[sl]) begin
      n.rx_full[sl] = 1'b1;
    end
    if (rx_push) begin
      n.rxf[s.rx_wp] = rx_word;
      n.rx_wp = s.rx_wp + 1'b1;
    end
    if (rx_pop) begin
      n.rx_rp = s.rx_rp + 1'b1;
    end
    if (tx_push) begin
      n.txf[s.tx_wp] = pwdata_in[ASP_WORD_W-1:0];
      n.tx_wp = s.tx_wp + 1'b1;
    end
    if (tx_pop) begin
      n.tx_rp = s.tx_rp + 1'b1;
    end
    n.rx_cnt = s.rx_cnt + ASP_CNT_W'(rx_push) - ASP_CNT_W'(rx_pop);
    n.tx_cnt = s.tx_cnt + ASP_CNT_W'(tx_push) - ASP_CNT_W'(tx_pop);
    // pin drivers and requests
    n.sck_oe = n.master && n.en;
    n.fs_oe  = n.master && n.en;
    n.aux_oe = n.master && n.en && n.slot_count_select != 2'h0;
    n.rx_irq = n.en && (~n.rx_slotn_dma_sel & n.rx_slot_assign) != '0 &&
               n.rx_cnt > n.rx_warn;
    n.tx_irq = n.en && (~n.tx_slotn_dma_sel & n.tx_slot_assign) != '0 &&
               n.tx_cnt <= n.tx_warn;
    n.rx_dreq = {4{n.en}} & n.rx_slotn_dma_sel & n.rx_full;
    n.tx_dreq = {4{n.en}} & n.tx_slotn_dma_sel & ~n.tx_full;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      s         <= '0;
      s.rx_warn <= ASP_RST_WARN;
      s.tx_warn <= ASP_RST_WARN;
    end else begin
      s <= n;
    end
  end

  assign prdata_out               = s.prdata;
  assign pready_out               = s.pready;
  assign pslverr_out              = s.pslverr;
  assign shift_clock_pin_out      = s.sck;
  assign shift_clock_pin_oe_out   = s.sck_oe;
  assign tx_frame_sync_pin_out    = s.fs_out;
  assign tx_frame_sync_pin_oe_out = s.fs_oe;
  assign ser_tx_data_pin_out      = s.tx_shift_reg[ASP_WORD_W-1];
  assign ser_tx_data_pin_oe_out   = s.tx_oe;
  assign rx_bit_clock_pin_out     = s.aux1;
  assign rx_bit_clock_pin_oe_out  = s.aux_oe;
  assign rx_frame_sync_pin_out    = s.aux2;
  assign rx_frame_sync_pin_oe_out = s.aux_oe;
  assign rx_irq_out               = s.rx_irq;
  assign tx_irq_out               = s.tx_irq;
  assign rx_dma_req_out           = s.rx_dreq;
  assign tx_dma_req_out           = s.tx_dreq;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence seq_rx_dma_word;
    fall_ev && s.in_frame && s.bit_cnt == last_bit &&
    s.rx_slot_assign[sl] && s.rx_slotn_dma_sel[sl];
  endsequence

  AST_TX_OE_SLOT: assert property (
    ser_tx_data_pin_oe_out |-> s.in_frame &&
      s.tx_slot_assign[s.slot_cnt[1:0]])
    else $error("tx data driven outside an assigned slot");
  AST_FS_STARTS_FRAME: assert property (
    $rose(tx_frame_sync_pin_out) |-> s.in_frame && s.bit_cnt == 4'h0 &&
      s.slot_cnt == 3'h0)
    else $error("frame sync did not restart the slot counter");
  AST_RX_DMA_FULL: assert property (
    seq_rx_dma_word ##1 s.en |-> rx_dma_req_out[$past(sl)])
    else $error("rx dma request missing after word");
  AST_TX_DMA_EMPTY: assert property (
    s.en && s.tx_slotn_dma_sel[0] && !s.tx_full[0] |-> tx_dma_req_out[0])
    else $error("tx dma request missing while empty");
  AST_RX_IRQ: assert property (
    s.en && s.rx_slot_assign[0] && !s.rx_slotn_dma_sel[0] &&
      s.rx_cnt > s.rx_warn |-> rx_irq_out)
    else $error("rx irq missing above warning limit");
  AST_TX_IRQ: assert property (
    tx_irq_out |-> s.tx_cnt <= s.tx_warn)
    else $error("tx irq above warning limit");
  AST_FIFO_CAP: assert property (
    s.rx_cnt <= DEPTH && s.tx_cnt <= DEPTH)
    else $error("fifo count beyond depth");
  AST_SLAVE_PINS: assert property (
    !s.master |-> !shift_clock_pin_oe_out && !tx_frame_sync_pin_oe_out)
    else $error("slave drives clock or sync");
  AST_AUX_SLOT1: assert property (
    $rose(rx_bit_clock_pin_out) |-> s.slot_cnt == 3'h1 && s.bit_cnt == 4'h0)
    else $error("aux sync one off slot one");
  AST_AUX_SLOT2: assert property (
    $rose(rx_frame_sync_pin_out) |-> s.slot_cnt == 3'h2 && s.bit_cnt == 4'h0)
    else $error("aux sync two off slot two");
endmodule
`default_nettype wire

// ==== verif/asp_codec_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-side codec: one word per slot after sync, captures tx bits
module asp_codec_model (
  input  wire logic        ref_clk_in,
  input  wire logic        bclk_in,
  input  wire logic        fs_in,
  input  wire logic        tx_data_in,
  input  wire logic        tx_oe_in,
  input  wire logic [4:0]  wlen_in,
  input  wire logic [2:0]  slots_in,
  output logic             rx_data_out,
  output logic [15:0]      tx_seen_out,
  output logic [7:0]       tx_bits_out,
  output logic [15:0]      frame_ns_out
);
  logic [15:0] words [4] = '{16'hC3A5, 16'h1E3C, 16'h7788, 16'h99AA};
  logic        bclk_q    = 1'b0;
  logic        fs_q      = 1'b0;
  int          idx       = 99;
  int          ocnt      = 0;
  int          obase     = 0;
  realtime     t_fs      = 0.0;
  initial begin
    rx_data_out  = 1'b0;
    tx_seen_out  = 16'h0000;
    tx_bits_out  = 8'h00;
    frame_ns_out = 16'h0000;
  end
  always @(posedge ref_clk_in) begin
    bclk_q <= bclk_in;
    fs_q   <= fs_in;
    if (fs_in && !fs_q) begin
      idx = 0;
      tx_bits_out  <= 8'(ocnt - obase);
      obase = ocnt;
      frame_ns_out <= 16'($rtoi($realtime - t_fs));
      t_fs = $realtime;
    end else if (bclk_in && !bclk_q) begin
      idx = idx + 1;
    end
    if ((fs_in && !fs_q) || (bclk_in && !bclk_q)) begin
      if (idx < wlen_in * slots_in)
        rx_data_out <= words[idx / wlen_in][wlen_in - 1 - idx % wlen_in];
      else // released line: no stale level
        rx_data_out <= ~rx_data_out;
    end
  end
  always @(negedge bclk_in) begin
    if (tx_oe_in) begin
      tx_seen_out <= {tx_seen_out[14:0], tx_data_in};
      ocnt = ocnt + 1;
    end
  end
endmodule
`default_nettype wire

// ==== verif/asp_serial_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_tb;
  import asp_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        clk_pri    = 1'b0;
  logic        clk_sec    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] paddr      = 32'h0;
  logic [31:0] pwdata     = 32'h0;
  logic [4:0]  cw         = 5'h08;
  logic [2:0]  cs         = 3'h1;
  logic [31:0] prdata;
  logic        pready, pslverr, sck_o, sck_oe, fs_o, fs_oe, txd, txd_oe;
  logic        rxd, aux1, aux1_oe, aux2, aux2_oe, rx_irq, tx_irq;
  logic [3:0]  rx_dma, tx_dma;
  logic [15:0] seen, fns;
  logic [7:0]  bits;
  logic [31:0] q;
  logic        e;
  wire logic   sck;
  wire logic   fs;
  int          num_errors = 0;
  int          checked    = 0;
  int          cycles     = 0;
  int          ph_pri     = 0;
  int          ph_sec     = 0;
  // board pull-downs while nobody drives clock or sync
  assign sck = sck_oe ? sck_o : 1'b0;
  assign fs  = fs_oe ? fs_o : 1'b0;
  always #2 ref_clk_in = ~ref_clk_in;
  // source clocks stepped from the reference, 250 phase steps per us
  always @(posedge ref_clk_in) begin
    ph_pri  <= (ph_pri + ASP_PRI_CLK_MHZ) % 250;
    ph_sec  <= (ph_sec + ASP_SEC_CLK_MHZ) % 250;
    clk_pri <= ph_pri < 125;
    clk_sec <= ph_sec < 125;
  end
  asp_serial_port asp_serial_port_i (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .clk_primary_in(clk_pri),
    .clk_secondary_in(clk_sec), .shift_clock_pin_in(sck),
    .shift_clock_pin_out(sck_o), .shift_clock_pin_oe_out(sck_oe),
    .tx_frame_sync_pin_in(fs), .tx_frame_sync_pin_out(fs_o),
    .tx_frame_sync_pin_oe_out(fs_oe), .ser_tx_data_pin_out(txd),
    .ser_tx_data_pin_oe_out(txd_oe), .ser_rx_data_pin_in(rxd),
    .rx_bit_clock_pin_out(aux1), .rx_bit_clock_pin_oe_out(aux1_oe),
    .rx_frame_sync_pin_out(aux2), .rx_frame_sync_pin_oe_out(aux2_oe),
    .rx_irq_out(rx_irq), .tx_irq_out(tx_irq), .rx_dma_req_out(rx_dma),
    .tx_dma_req_out(tx_dma));
  asp_codec_model asp_codec_model_i (
    .ref_clk_in(ref_clk_in), .bclk_in(sck), .fs_in(fs), .tx_data_in(txd),
    .tx_oe_in(txd_oe), .wlen_in(cw), .slots_in(cs), .rx_data_out(rxd),
    .tx_seen_out(seen), .tx_bits_out(bits), .frame_ns_out(fns));
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {24'h000000, a};
    pwdata  <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic near(input string n, input int x, input logic [15:0] g);
    checked++;
    if ($isunknown(g) || g > x + 8 || g + 8 < x) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", n, x, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string n);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  function automatic logic [31:0] ctrl(logic en, logic sec, logic w16,
      logic [1:0] scs, logic [7:0] bc, logic [6:0] fc);
    return (32'(en) << ASP_CTRL_EN) | (32'h1 << ASP_CTRL_MASTER) |
           (32'(sec) << ASP_CTRL_CLKSEL) | (32'(w16) << ASP_CTRL_WORD16) |
           (32'(scs) << ASP_CTRL_SCS) | (32'(bc) << ASP_CTRL_BCPRS) |
           (32'(fc) << ASP_CTRL_FRAME_CLOCK_DIVIDER);
  endfunction
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard: both phases need well under half of this
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    rd(ASP_OFS_WARN, 32'h0000_0808, "warn reset");
    rd(ASP_OFS_STAT, 32'h0, "stat reset");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    // three 8-bit slots; 0 via fifo, 2 via dma, 1 left to others
    apb(1'b1, ASP_OFS_SLOT, 32'h0000_4455);
    apb(1'b1, ASP_OFS_WARN, 32'h0000_0100);
    for (int i = 1; i < 4; i++) apb(1'b1, ASP_OFS_TXFIFO, 32'(i * 17));
    apb(1'b1, ASP_OFS_TXHOLD + 8'h08, 32'h5A);
    apb(1'b1, ASP_OFS_CTRL, ctrl(1'b0, 1'b1, 1'b0, 2'h2, 8'h01, 7'h19));
    rd(ASP_OFS_STAT, 32'h0040_0300, "stat loaded");
    cs = 3'h3;
    apb(1'b1, ASP_OFS_CTRL,
        ctrl(1'b1, 1'b1, 1'b0, 2'h2, 8'h01, 7'h19));
    repeat (20) @(posedge fs);
    near("frame ns", 1083, fns);
    chk("tx bits", 32'd16, {24'h0, bits});
    chk("tx word", 32'h335A, {16'h0, seen});
    chk("irq", 32'h3, {30'h0, rx_irq, tx_irq});
    chk("dma req", 32'h44, {24'h0, rx_dma, tx_dma});
    chk("aux oe", 32'h3, {30'h0, aux1_oe, aux2_oe});
    rd(ASP_OFS_STAT, 32'h0004_0010, "stat full");
    rd(ASP_OFS_RXFIFO, 32'hA5, "rx fifo");
    rd(ASP_OFS_RXHOLD + 8'h08, 32'h88, "rx hold 2");
    rd(ASP_OFS_RXHOLD + 8'h04, 32'h0, "rx hold 1");
    // normal mode: one 16-bit slot through holding zero both ways
    apb(1'b1, ASP_OFS_CTRL,
        ctrl(1'b0, 1'b0, 1'b1, 2'h0, 8'h00, 7'h11));
    apb(1'b1, ASP_OFS_SLOT, 32'h0000_1111);
    apb(1'b1, ASP_OFS_TXHOLD, 32'h9617);
    cw = 5'h10;
    cs = 3'h1;
    apb(1'b1, ASP_OFS_CTRL, ctrl(1'b1, 1'b0, 1'b1, 2'h0, 8'h00, 7'h11));
    repeat (6) @(posedge fs);
    near("frame ns", 1500, fns);
    chk("tx bits", 32'd16, {24'h0, bits});
    chk("tx word", 32'h9617, {16'h0, seen});
    chk("dma req", 32'h11, {24'h0, rx_dma, tx_dma});
    chk("irq", 32'h0, {30'h0, rx_irq, tx_irq});
    chk("aux oe", 32'h0, {30'h0, aux1_oe, aux2_oe});
    rd(ASP_OFS_RXHOLD, 32'hC3A5, "rx hold 0");
    end_sim();
  end
endmodule
`default_nettype wire
